// ---- src/astc_device.v ----
/*
  serial control and readout side of a 10-bit converter: chip-select filter,
  address shift-in, result shift-out, end-of-conversion flag, self-test codes.
  assumes host pins are asynchronous; the converter core hands results over
  a valid/ready stream buffered in a 16-word fifo.
  limitation: a select pulse shorter than the filter time is never seen, and
  a conversion that finds the fifo empty holds the flag low until a word comes.
*/
`timescale 1ns/1ps
`include "astc_map.vh"
module astc_device #(
  parameter CONV_CYC = `ASTC_CONV_CYC,
  parameter FILT_CYC = `ASTC_CS_FILTER_CYC,
  parameter FIFO_DEPTH = 16
) (
  input wire clk, // system clock 50 MHz
  input wire reset_n, // async reset, active low
  input wire chipSelect_n, // host chip select, active low
  input wire ioClock, // host shift clock
  input wire addrIn, // host address bit
  output reg dataOut, // result bit
  output reg dataOutEn, // drive enable for result bit
  output reg convDone, // end-of-conversion flag
  output reg [3:0] chanSel, // channel presented to the analog core
  output reg sampleOn, // acquisition window active
  input wire [13:0] coreData, // {over, under, code} from analog core
  input wire coreValid, // core result valid
  output wire coreReady // fifo can take a result
);
  // transfer phases: idle, shifting, converting, trailing pulses of a long frame
  localparam ST_IDLE = 2'h0;
  localparam ST_SHIFT = 2'h1;
  localparam ST_CONV = 2'h2;
  localparam ST_TAIL = 2'h3;
  reg [1:0] state;
  reg [2:0] csSync;
  reg [1:0] clkSync;
  reg addrS1;
  reg addrS2;
  reg clkPrev;
  reg enabled;
  // filter, pulse and conversion counters
  reg [11:0] filtCnt;
  reg [4:0] edgeCnt;
  reg [3:0] addrShift;
  reg [3:0] convAddr;
  reg [9:0] outShift;
  reg [9:0] result;
  reg [23:0] convCnt;
  // set when the host keeps clocking past the tenth pulse during conversion
  reg longXfer;
  // select edges arrive three clocks late, shift clock edges two; the link clock is far slower, so none is missed
  wire csLow = !csSync[2];
  wire rise = clkSync[1] && !clkPrev;
  wire fall = !clkSync[1] && clkPrev;
  wire [13:0] fifoData;
  wire fifoValid;
  wire takeResult = (state == ST_CONV) && (convCnt == 24'h0) && fifoValid;
  wire [9:0] next_code = fifoData[13] ? `ASTC_CODE_HIGH : fifoData[12] ? `ASTC_CODE_LOW : fifoData[9:0];
  reg [9:0] next_result;
  astc_fifo #(.WIDTH(14), .DEPTH(FIFO_DEPTH), .AW(4)) fifo (
    .clk(clk),
    .reset_n(reset_n),
    .inData(coreData),
    .inValid(coreValid),
    .inReady(coreReady),
    .outData(fifoData),
    .outValid(fifoValid),
    .outReady(takeResult)
  );
  // self-test addresses bypass the analog code; range clamp otherwise
  always @* begin
    case (convAddr)
      `ASTC_ADDR_MID: next_result = `ASTC_CODE_MID;
      `ASTC_ADDR_LOW: next_result = `ASTC_CODE_LOW;
      `ASTC_ADDR_HIGH: next_result = `ASTC_CODE_HIGH;
      default: next_result = next_code;
    endcase
  end
  // two flops on the shift clock and address pins, three on select, before any logic looks at them
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      csSync <= 3'h7;
      clkSync <= 2'h0;
      addrS1 <= 1'b0;
      addrS2 <= 1'b0;
      clkPrev <= 1'b0;
    end else begin
      csSync <= {csSync[1:0], chipSelect_n};
      clkSync <= {clkSync[0], ioClock};
      addrS1 <= addrIn;
      addrS2 <= addrS1;
      clkPrev <= clkSync[1];
    end
  end
  // select must hold its level for the filter time before it counts
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      enabled <= 1'b0;
      filtCnt <= 12'h0;
    end else if (csLow == enabled) begin
      filtCnt <= 12'h0;
    end else if (filtCnt >= FILT_CYC[11:0] - 12'h1) begin
      enabled <= csLow;
      filtCnt <= 12'h0;
    end else begin
      filtCnt <= filtCnt + 12'h1;
    end
  end
  // transfer engine: shift, acquire, convert
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= ST_IDLE;
      edgeCnt <= 5'h0;
      addrShift <= 4'h0;
      convAddr <= 4'h0;
      outShift <= 10'h0;
      result <= 10'h0;
      convCnt <= 24'h0;
      dataOut <= 1'b0;
      dataOutEn <= 1'b0;
      convDone <= 1'b1;
      chanSel <= 4'h0;
      sampleOn <= 1'b0;
      longXfer <= 1'b0;
    end else begin
      dataOutEn <= enabled;
      case (state)
        ST_IDLE: begin
          edgeCnt <= 5'h0;
          outShift <= result;
          dataOut <= result[9];
          longXfer <= 1'b0;
          // the first rising edge already carries the address msb
          if (enabled && rise) begin
            addrShift <= {addrShift[2:0], addrS2};
            state <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          // extra pulses up to 16 are tolerated and ignored
          if (!enabled) begin
            state <= ST_IDLE;
            sampleOn <= 1'b0;
          end
          if (rise && edgeCnt < 5'h4) begin
            addrShift <= {addrShift[2:0], addrS2};
          end
          if (fall && enabled) begin
            edgeCnt <= edgeCnt + 5'h1;
            outShift <= {outShift[8:0], 1'b0};
            dataOut <= outShift[8];
            if (edgeCnt == 5'h3) begin
              chanSel <= addrShift;
              sampleOn <= 1'b1;
            end
            if (edgeCnt == `ASTC_SHORT_LEN - 5'h1) begin
              convAddr <= addrShift;
              sampleOn <= 1'b0;
              convDone <= 1'b0;
              convCnt <= CONV_CYC[23:0];
              state <= ST_CONV;
            end
          end
        end
        ST_CONV: begin
          // long transfers keep clocking; later edges carry no data but are counted
          if (rise && enabled) begin
            longXfer <= 1'b1;
          end
          if (fall && enabled && edgeCnt != `ASTC_LONG_LEN) begin
            edgeCnt <= edgeCnt + 5'h1;
          end
          if (convCnt != 24'h0) begin
            convCnt <= convCnt - 24'h1;
          end else if (fifoValid) begin
            result <= next_result;
            outShift <= next_result;
            dataOut <= next_result[9];
            convDone <= 1'b1;
            // a frame still being clocked must run out, else its tail would open a new one
            if (longXfer && enabled && edgeCnt != `ASTC_LONG_LEN) begin
              state <= ST_TAIL;
            end else begin
              state <= ST_IDLE;
            end
          end
        end
        ST_TAIL: begin
          // remaining pulses of an 11- to 16-pulse frame are swallowed here
          if (!enabled) begin
            state <= ST_IDLE;
          end else if (edgeCnt == `ASTC_LONG_LEN) begin
            state <= ST_IDLE;
          end else if (fall) begin
            edgeCnt <= edgeCnt + 5'h1;
            if (edgeCnt == `ASTC_LONG_LEN - 5'h1) begin
              state <= ST_IDLE;
            end
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
endmodule

// ---- src/astc_map.vh ----
/*
  constants for the serial converter transfer block: pin filter timing,
  transfer lengths, self-test addresses and codes.
  assumes a 50 MHz system clock.
*/
`ifndef ASTC_MAP_VH
`define ASTC_MAP_VH
`define ASTC_CLK_NS 20
`define ASTC_CS_FILTER_NS 1425
`define ASTC_CS_FILTER_CYC ((`ASTC_CS_FILTER_NS + `ASTC_CLK_NS - 1) / `ASTC_CLK_NS)
`define ASTC_CONV_US 21
`define ASTC_CONV_CYC ((`ASTC_CONV_US * 1000) / `ASTC_CLK_NS)
`define ASTC_ACQ_PERIODS 4'h6
`define ASTC_SHORT_LEN 5'h0a
`define ASTC_LONG_LEN 5'h10
`define ASTC_ADDR_MID 4'hb
`define ASTC_ADDR_LOW 4'hc
`define ASTC_ADDR_HIGH 4'hd
`define ASTC_CODE_MID 10'h200
`define ASTC_CODE_LOW 10'h000
`define ASTC_CODE_HIGH 10'h3ff
`define ASTC_RES_BITS 10
`endif

// ---- src/astc_fifo.v ----
/*
  small synchronous fifo with valid/ready on both sides.
  assumes one clock and asynchronous active-low reset.
*/
`timescale 1ns/1ps
module astc_fifo #(
  parameter WIDTH = 14,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire clk, // system clock
  input wire reset_n, // async reset, active low
  input wire [WIDTH-1:0] inData, // write word
  input wire inValid, // write request
  output wire inReady, // room available
  output wire [WIDTH-1:0] outData, // head word
  output wire outValid, // head present
  input wire outReady // consumer takes head
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wrPtr;
  reg [AW-1:0] rdPtr;
  reg [AW:0] count;
  reg [AW:0] next_count;
  reg roomLeft;
  reg haveData;
  wire doWrite = inValid && roomLeft;
  wire doRead = haveData && outReady;
  // flags are registered so that ports fed by them come straight from flops
  assign inReady = roomLeft;
  assign outValid = haveData;
  assign outData = mem[rdPtr];
  // storage has no reset; pointers, count and flags are the control state
  always @(posedge clk) begin
    if (doWrite) begin
      mem[wrPtr] <= inData;
    end
  end
  // occupancy after this edge
  always @* begin
    next_count = count;
    if (doWrite && !doRead) begin
      next_count = count + {{AW{1'b0}}, 1'b1};
    end else if (doRead && !doWrite) begin
      next_count = count - {{AW{1'b0}}, 1'b1};
    end
  end
  // pointers wrap naturally at power-of-two depth
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wrPtr <= {AW{1'b0}};
      rdPtr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
      roomLeft <= 1'b1;
      haveData <= 1'b0;
    end else begin
      if (doWrite) begin
        wrPtr <= wrPtr + {{(AW-1){1'b0}}, 1'b1};
      end
      if (doRead) begin
        rdPtr <= rdPtr + {{(AW-1){1'b0}}, 1'b1};
      end
      count <= next_count;
      roomLeft <= (next_count != DEPTH[AW:0]);
      haveData <= (next_count != {(AW+1){1'b0}});
    end
  end
endmodule

// ---- verification/astc_host.sv ----
/* host serial port model: select, shift clock and address out, result in.
   assumes 20 ns clk steps; the shift clock idles low between frames */
`timescale 1ns/1ps
module astc_host (
  input wire logic clk, // edge alignment
  input wire logic dataOut, // result bit
  input wire logic dataOutEn, // result drive enable
  output logic chipSelect_n, // select, low active
  output logic ioClock, // 160 ns shift clock
  output logic addrIn // address bit
);
  logic [9:0] res = 10'h000;
  initial {chipSelect_n, ioClock, addrIn} = 3'b100;
  // address msb first; spare pulses toggle it so no stale level stands
  task automatic pulses(input int n, input logic [3:0] a);
    for (int i = 0; i < n; i++) begin
      addrIn = i < 4 ? a[3 - i] : ~addrIn;
      #80 ioClock = 1'b1;
      // an undriven pin reads back inverted so a released output cannot pass
      if (i < 10) res = {res[8:0], dataOutEn ? dataOut : ~dataOut};
      #80 ioClock = 1'b0;
    end
  endtask
  // waits out the select filter on both edges so no pulse is lost
  task automatic xfer(input logic [3:0] a, input int n, input bit framed);
    @(posedge clk);
    #1;
    if (chipSelect_n) begin
      chipSelect_n = 1'b0;
      #1600;
    end
    pulses(n, a);
    #200;
    if (framed) begin
      chipSelect_n = 1'b1;
      #1600;
    end
  endtask
endmodule

// ---- verification/astc_device_asserts.sv ----
/* port checker for the serial converter block.
   assumes host pins change far slower than clk */
`timescale 1ns/1ps
module astc_device_asserts #(parameter int FILT_CYC = 72, parameter int CONV_CYC = 1050) (
  input wire logic clk, // system clock
  input wire logic reset_n, // async reset
  input wire logic chipSelect_n, // host select
  input wire logic dataOut, // result bit
  input wire logic dataOutEn, // pin drive
  input wire logic convDone, // conversion flag
  input wire logic [3:0] chanSel, // channel
  input wire logic sampleOn // sample window
);
  localparam int OFF_LIM = FILT_CYC + 8;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // select filter, sample window, conversion flag timing and self-test codes
  AST_EN_OFF: assert property ($rose(chipSelect_n) |-> ##[1:OFF_LIM] !dataOutEn) else $error("drive kept");
  AST_EN_ON: assert property ($fell(chipSelect_n) |=> !dataOutEn [*8]) else $error("drive early");
  AST_NOFILT: assert property ($rose(sampleOn) |-> dataOutEn) else $error("edge in filter");
  AST_CHAN: assert property (sampleOn && $past(sampleOn) |-> $stable(chanSel)) else $error("chan moved");
  AST_EOC_LOW: assert property ($fell(sampleOn) && !chipSelect_n |-> ##[0:8] !convDone) else $error("no fall");
  AST_EOC_HOLD: assert property ($fell(convDone) |=> !convDone [*8]) else $error("flag short");
  AST_SELF_HI: assert property ($rose(convDone) && chanSel == 4'hd |-> ##[0:2] dataOut) else $error("msb 0");
  AST_SELF_LO: assert property ($rose(convDone) && chanSel == 4'hc |-> ##[0:2] !dataOut) else $error("msb 1");
  cover property ($rose(convDone));
  cover property ($fell(sampleOn));
  cover property ($rose(chipSelect_n) && dataOutEn);
endmodule
bind astc_device astc_device_asserts #(.FILT_CYC(FILT_CYC), .CONV_CYC(CONV_CYC)) i_astc_device_asserts (.*);

// ---- verification/astc_device_test.sv ----
/* bench for the serial converter block: the host model drives the pins,
   the bench feeds the core fifo and compares the codes read back */
`timescale 1ns/1ps
module astc_device_test;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [13:0] coreData = 14'h0000;
  logic coreValid = 1'b0;
  wire chipSelect_n, ioClock, addrIn, dataOut, dataOutEn, convDone, coreReady, sampleOn;
  wire [3:0] chanSel;
  int n_errors = 0;
  int check_count = 0;
  int cycles = 0;
  // framed, pulses, address, core word, expected code
  logic [43:0] rows [7] = '{44'h10ad01233ff, 44'h10bc0155000, 44'h110b02aa200, 44'h10c502a52a5,
    44'h00a320113ff, 44'h01071322000, 44'h010a30553ff};
  always #10 clk = ~clk;
  astc_device #(.CONV_CYC(20)) i_astc_device (
    .clk(clk),
    .reset_n(reset_n),
    .chipSelect_n(chipSelect_n),
    .ioClock(ioClock),
    .addrIn(addrIn),
    .dataOut(dataOut),
    .dataOutEn(dataOutEn),
    .convDone(convDone),
    .chanSel(chanSel),
    .sampleOn(sampleOn),
    .coreData(coreData),
    .coreValid(coreValid),
    .coreReady(coreReady)
  );
  astc_host i_astc_host (
    .clk(clk),
    .dataOut(dataOut),
    .dataOutEn(dataOutEn),
    .chipSelect_n(chipSelect_n),
    .ioClock(ioClock),
    .addrIn(addrIn)
  );
  task finish_test;
    if (n_errors == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task chk(input logic [15:0] got, input logic [15:0] want);
    check_count++;
    if (got !== want) begin
      n_errors++;
      $display("MISMATCH %0t %h %h", $time, got, want);
    end
  endtask
  // valid stays up until ready is seen at an edge
  task push(input logic [13:0] w);
    @(posedge clk);
    #1 coreData = w;
    coreValid = 1'b1;
    @(posedge clk);
    while (coreReady !== 1'b1) @(posedge clk);
    #1 coreValid = 1'b0;
  endtask
  // bounded wait for the flag so the next transfer never starts early
  task run(input logic [3:0] a, input int n, input bit f);
    i_astc_host.xfer(a, n, f);
    for (int k = 0; k < 99 && convDone !== 1'b1; k++) @(posedge clk);
    chk(16'(convDone), 16'h0001);
  endtask
  // hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      n_errors++;
      finish_test();
    end
  end
  initial begin
    repeat (2) @(posedge clk);
    #1 reset_n = 1'b1;
    chk({dataOutEn, sampleOn, convDone, chanSel}, 16'h0010);
    for (int i = 0; i < 7; i++) begin
      push(rows[i][25:12]);
      run(rows[i][31:28], int'(rows[i][39:32]), rows[i][40]);
      if (i > 0) chk(i_astc_host.res, rows[i - 1][9:0]);
      chk(chanSel, rows[i][31:28]);
    end
    // fill the fifo until it refuses, then drain it with unframed transfers
    for (int k = 0; k < 16; k++) push(14'(k));
    chk(coreReady, 1'b0);
    for (int k = 0; k < 16; k++) begin
      run(4'h0, 10, 1'b0);
      chk(i_astc_host.res, k == 0 ? 10'h3ff : 10'(k - 1));
    end
    // pulses inside the select filter are ignored; then an abort in mid address
    @(posedge clk);
    #1 i_astc_host.chipSelect_n = 1'b1;
    #1600 i_astc_host.chipSelect_n = 1'b0;
    i_astc_host.pulses(6, 4'hd);
    #800 chk({sampleOn, chanSel}, 16'h0000);
    i_astc_host.pulses(3, 4'h9);
    i_astc_host.chipSelect_n = 1'b1;
    #1600 chk({dataOutEn, sampleOn, convDone}, 16'h0001);
    push(14'h03c3);
    run(4'h5, 10, 1'b1);
    push(14'h0000);
    run(4'h0, 10, 1'b1);
    chk(i_astc_host.res, 16'h03c3);
    finish_test();
  end
endmodule
